// ===== verilog/pag_pkg.sv
// pag_pkg: shared constants for the programmable address generator link
// assumes a single 40 MHz clock shared by scheduler and generator
package pag_pkg;
    localparam int ADDR_W      = 20;
    localparam int DATA_W      = 8;
    localparam int CFG_REGS    = 20;
    localparam int PAT_DEPTH   = 32;
    localparam int CHAN_W      = 5;
    localparam int CFG_IDX_W   = 5;
    localparam int PAT_IDX_W   = 5;
    // register_latch_select codes
    localparam logic [1:0] SEL_ADDR_REG  = 2'h0;
    localparam logic [1:0] SEL_CFG_DATA  = 2'h1;
    localparam logic [1:0] SEL_PAT_DATA  = 2'h2;
    localparam logic [1:0] SEL_EXT_DATA  = 2'h3;
    // configuration register indices
    localparam logic [4:0] CFG_BASE0     = 5'h00;
    localparam logic [4:0] CFG_BASE1     = 5'h01;
    localparam logic [4:0] CFG_BASE2     = 5'h02;
    localparam logic [4:0] CFG_LEN0      = 5'h03;
    localparam logic [4:0] CFG_LEN1      = 5'h04;
    localparam logic [4:0] CFG_LEN2      = 5'h05;
    localparam logic [4:0] CFG_PAT_CNT   = 5'h06;
    localparam logic [4:0] CFG_MODE      = 5'h07;
    localparam logic [4:0] CFG_PO_POS0   = 5'h08;
    localparam logic [4:0] CFG_PO_POS1   = 5'h09;
    localparam logic [4:0] CFG_PO_POS2   = 5'h0A;
    localparam logic [4:0] CFG_CBUF_SZ0  = 5'h0B;
    localparam logic [4:0] CFG_CBUF_SZ1  = 5'h0C;
    localparam logic [4:0] CFG_CBUF_SZ2  = 5'h0D;
    // mode bits
    localparam int MODE_EXT_BIT  = 0;
    localparam int MODE_CBUF_BIT = 1;
    localparam int MODE_WE_BIT   = 2;
    // reset values
    localparam logic [7:0] CFG_RST_DEFAULT = 8'h00;
    localparam logic [7:0] CFG_LEN0_RST    = 8'hFF;
    localparam logic [7:0] CFG_PAT_CNT_RST = 8'h01;
    localparam logic [7:0] PAT_RST         = 8'h01;
endpackage

// ===== verilog/pag_if.sv
// pag_if: pins between scheduler end and address generator end
// assumes both ends share clk and the start strobe
`timescale 1ns/100ps
`default_nettype none
interface pag_if;
    logic                          chip_select_b;
    logic                          write_not_read;
    logic [1:0]                    register_latch_select;
    logic                          strobe;
    logic [pag_pkg::DATA_W-1:0]    config_data_bus;
    logic                          start;
    logic [pag_pkg::CHAN_W-1:0]    channel_select_lines;
    logic                          ext_req;
    logic [pag_pkg::PAT_IDX_W+2:0] ext_index;
    logic                          ext_valid;
    logic                          terminal_count;
    logic                          program_out_flag;

    modport generator (
        input  chip_select_b, write_not_read, register_latch_select, strobe, config_data_bus,
        input  start, channel_select_lines, ext_valid,
        output ext_req, ext_index, terminal_count, program_out_flag
    );
    modport scheduler (
        output chip_select_b, write_not_read, register_latch_select, strobe, config_data_bus,
        output start, channel_select_lines, ext_valid,
        input  ext_req, ext_index, terminal_count, program_out_flag
    );
endinterface
`default_nettype wire

// ===== verilog/pag_generator.sv
// pag_generator: address generator end, loaded over the byte bus, emits 20-bit address arrays
// assumes clk shared with the DSP and the scheduler; link signals are same-domain logic
// Overview of operation
// [RULE_01] local mode reads up to 32 stored patterns
// [RULE_02] twenty config registers, defaults, write before start
// [RULE_03] start begins address array generation
// [RULE_04] address output is 20 bits wide
// [RULE_05] too many patterns: fetch patterns over bus
// [RULE_06] terminal count at end, then idle
// [RULE_07] drive program-out flag for scheduler or DSP
// [RULE_08] channel select picks circular buffer
// [RULE_09] few channels direct, many via decoder
// [RULE_10] data/coefficient use leaves channel inputs idle
// [RULE_11] drive memory write enable and read strobe
// [RULE_12] scheduler drives address/latch select lines
// [RULE_13] own chip select and terminal count each
// [RULE_14] common clock and start with DSP
`timescale 1ns/100ps
`default_nettype none
module pag_generator #(
    parameter int ADDR_W    = pag_pkg::ADDR_W,
    parameter int PAT_DEPTH = pag_pkg::PAT_DEPTH
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    pag_if.generator               link,
    output logic [ADDR_W-1:0]      address_out,
    output logic                   address_valid,
    output logic                   write_enable,
    output logic                   read_strobe_clock,
    output logic                   busy
);
    typedef enum logic [3:0] {
        PAG_IDLE  = 4'b0001,
        PAG_FETCH = 4'b0010,
        PAG_RUN   = 4'b0100,
        PAG_DONE  = 4'b1000
    } pag_state_t;

    typedef struct packed {
        pag_state_t                                   state;
        logic [pag_pkg::CFG_REGS-1:0][7:0]            cfg;
        logic [PAT_DEPTH-1:0][7:0]                    pat;
        logic [4:0]                                   addr_ptr;
        logic [pag_pkg::PAT_IDX_W:0]                  pat_idx;
        logic [7:0]                                   step;
        logic [ADDR_W-1:0]                            base;
        logic [ADDR_W-1:0]                            offset;
        logic [ADDR_W-1:0]                            count;
        logic [ADDR_W-1:0]                            address;
        logic                                         valid;
        logic                                         we;
        logic                                         rd;
        logic                                         tc;
        logic                                         po;
        logic                                         ext_req;
    } pag_gen_t;

    pag_gen_t s_reg;
    pag_gen_t s_next;

    function automatic logic [ADDR_W-1:0] pag_word(input logic [7:0] b0, input logic [7:0] b1,
                                                   input logic [7:0] b2);
        logic [23:0] w;
        w = {b2, b1, b0};
        return w[ADDR_W-1:0];
    endfunction

    // next offset, folded back into the circular buffer when enabled
    function automatic logic [ADDR_W-1:0] pag_next_off(input logic [ADDR_W-1:0] off, input logic [7:0] stp,
                                                       input logic [ADDR_W-1:0] size, input logic circ);
        logic [ADDR_W-1:0] sum;
        sum = off + ADDR_W'(stp);
        if (circ && size != '0 && sum >= size) begin
            sum = sum - size;
        end
        return sum;
    endfunction

    logic [ADDR_W-1:0] len_w;
    logic [ADDR_W-1:0] po_w;
    logic [ADDR_W-1:0] cbuf_w;
    logic              ext_mode;
    logic              cbuf_mode;
    logic [7:0]        pat_cnt;
    logic              bus_wr;

    always_comb begin
        len_w     = pag_word(s_reg.cfg[pag_pkg::CFG_LEN0], s_reg.cfg[pag_pkg::CFG_LEN1],
                             s_reg.cfg[pag_pkg::CFG_LEN2]);
        po_w      = pag_word(s_reg.cfg[pag_pkg::CFG_PO_POS0], s_reg.cfg[pag_pkg::CFG_PO_POS1],
                             s_reg.cfg[pag_pkg::CFG_PO_POS2]);
        cbuf_w    = pag_word(s_reg.cfg[pag_pkg::CFG_CBUF_SZ0], s_reg.cfg[pag_pkg::CFG_CBUF_SZ1],
                             s_reg.cfg[pag_pkg::CFG_CBUF_SZ2]);
        pat_cnt   = s_reg.cfg[pag_pkg::CFG_PAT_CNT];
        // external pattern mode when forced or when patterns exceed local store
        ext_mode  = s_reg.cfg[pag_pkg::CFG_MODE][pag_pkg::MODE_EXT_BIT]
                    || (pat_cnt > 8'(PAT_DEPTH));  // [RULE_05]
        cbuf_mode = s_reg.cfg[pag_pkg::CFG_MODE][pag_pkg::MODE_CBUF_BIT];
        bus_wr    = !link.chip_select_b && link.write_not_read && link.strobe;  // [RULE_13]
    end

    always_comb begin
        s_next       = s_reg;
        s_next.valid = 1'b0;
        s_next.we    = 1'b0;
        s_next.rd    = 1'b0;
        s_next.tc    = 1'b0;
        s_next.po    = 1'b0;
        case (s_reg.state)
            PAG_IDLE: begin
                // programming over the byte bus only while idle
                if (bus_wr) begin
                    if (link.register_latch_select == pag_pkg::SEL_ADDR_REG) begin  // [RULE_12]
                        s_next.addr_ptr = link.config_data_bus[4:0];
                    end else if (link.register_latch_select == pag_pkg::SEL_CFG_DATA) begin
                        if (s_reg.addr_ptr < 5'(pag_pkg::CFG_REGS)) begin
                            s_next.cfg[s_reg.addr_ptr] = link.config_data_bus;  // [RULE_02]
                        end
                        s_next.addr_ptr = s_reg.addr_ptr + 5'h01;
                    end else if (link.register_latch_select == pag_pkg::SEL_PAT_DATA) begin
                        s_next.pat[s_reg.addr_ptr] = link.config_data_bus;  // [RULE_01]
                        s_next.addr_ptr = s_reg.addr_ptr + 5'h01;
                    end
                end
                if (link.start) begin  // [RULE_03] [RULE_14]
                    s_next.base    = '0;
                    // circular buffer origin from requesting channel
                    if (cbuf_mode) begin
                        s_next.base = ADDR_W'(link.channel_select_lines) * cbuf_w;  // [RULE_08] [RULE_09] [RULE_10]
                    end
                    s_next.offset  = '0;
                    s_next.count   = '0;
                    s_next.pat_idx = '0;
                    s_next.ext_req = ext_mode;
                    s_next.state   = ext_mode ? PAG_FETCH : PAG_RUN;
                    s_next.step    = s_reg.pat[0];
                end
            end
            PAG_FETCH: begin
                // wait for scheduler to supply the next pattern byte
                if (link.ext_valid) begin  // [RULE_05]
                    s_next.step    = link.config_data_bus;
                    s_next.ext_req = 1'b0;
                    s_next.state   = PAG_RUN;
                end
            end
            PAG_RUN: begin
                s_next.address = s_reg.base + s_reg.offset;  // [RULE_04]
                s_next.valid   = 1'b1;
                s_next.we      = s_reg.cfg[pag_pkg::CFG_MODE][pag_pkg::MODE_WE_BIT];  // [RULE_11]
                s_next.rd      = 1'b1;  // [RULE_11]
                s_next.po      = (s_reg.count == po_w);  // [RULE_07]
                s_next.offset  = pag_next_off(s_reg.offset, s_reg.step, cbuf_w, cbuf_mode);  // [RULE_08]
                s_next.count   = s_reg.count + 1'b1;
                s_next.pat_idx = s_reg.pat_idx + 1'b1;
                if (pat_cnt != 8'h00 && s_reg.pat_idx + 1'b1 >= 6'(pat_cnt)) begin
                    s_next.pat_idx = '0;
                end
                if (ext_mode) begin
                    s_next.ext_req = 1'b1;
                    s_next.state   = PAG_FETCH;
                end else begin
                    s_next.step = s_reg.pat[s_next.pat_idx[4:0]];  // [RULE_01]
                end
                if (s_reg.count == len_w) begin
                    s_next.ext_req = 1'b0;
                    s_next.state   = PAG_DONE;
                end
            end
            PAG_DONE: begin
                s_next.tc    = 1'b1;  // [RULE_06]
                s_next.state = PAG_IDLE;
            end
            default: begin
                s_next.state = PAG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_reg          <= '0;
            s_reg.state    <= PAG_IDLE;
            for (int i = 0; i < pag_pkg::CFG_REGS; i++) begin
                s_reg.cfg[i] <= pag_pkg::CFG_RST_DEFAULT;
            end
            s_reg.cfg[pag_pkg::CFG_LEN0]    <= pag_pkg::CFG_LEN0_RST;
            s_reg.cfg[pag_pkg::CFG_PAT_CNT] <= pag_pkg::CFG_PAT_CNT_RST;
            for (int i = 0; i < PAT_DEPTH; i++) begin
                s_reg.pat[i] <= pag_pkg::PAT_RST;
            end
        end else begin
            s_reg <= s_next;
        end
    end

    assign address_out           = s_reg.address;
    assign address_valid         = s_reg.valid;
    assign write_enable          = s_reg.we;
    assign read_strobe_clock     = s_reg.rd;
    assign busy                  = (s_reg.state != PAG_IDLE);
    assign link.terminal_count   = s_reg.tc;
    assign link.program_out_flag = s_reg.po;
    assign link.ext_req          = s_reg.ext_req;
    assign link.ext_index        = {2'h0, s_reg.pat_idx};
endmodule
`default_nettype wire

// ===== verilog/pag_scheduler.sv
// pag_scheduler: scheduler end, programs one generator and starts it
// assumes same clk as the generator; user side issues one command per request
`timescale 1ns/100ps
`default_nettype none
module pag_scheduler (
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    pag_if.scheduler                         link,
    input  wire logic                        cmd_valid,
    input  wire logic [1:0]                  cmd_select,
    input  wire logic [pag_pkg::DATA_W-1:0]  cmd_data,
    input  wire logic                        cmd_start,
    input  wire logic [pag_pkg::CHAN_W-1:0]  channel_code,
    input  wire logic                        ext_data_valid,
    input  wire logic [pag_pkg::DATA_W-1:0]  ext_data,
    output logic                             cmd_ready,
    output logic                             ext_fetch_req,
    output logic [pag_pkg::PAT_IDX_W+2:0]    ext_fetch_index,
    output logic                             done_pulse,
    output logic                             flag_pulse
);
    typedef struct packed {
        logic                       cs_b;
        logic                       wr;
        logic [1:0]                 sel;
        logic                       strobe;
        logic [pag_pkg::DATA_W-1:0] data;
        logic                       start;
        logic [pag_pkg::CHAN_W-1:0] chan;
        logic                       ext_valid;
        logic                       running;
        logic                       done;
        logic                       flag;
    } pag_sch_t;

    pag_sch_t s_reg;
    pag_sch_t s_next;

    always_comb begin
        s_next           = s_reg;
        s_next.strobe    = 1'b0;
        s_next.start     = 1'b0;
        s_next.ext_valid = 1'b0;
        s_next.cs_b      = 1'b1;
        s_next.done      = link.terminal_count;
        s_next.flag      = link.program_out_flag;
        if (!s_reg.running && cmd_valid) begin
            s_next.cs_b   = 1'b0;  // [RULE_13]
            s_next.wr     = 1'b1;
            s_next.sel    = cmd_select;  // [RULE_12]
            s_next.data   = cmd_data;
            s_next.strobe = 1'b1;
        end else if (!s_reg.running && cmd_start) begin
            s_next.start   = 1'b1;  // [RULE_14]
            s_next.chan    = channel_code;  // [RULE_09] [RULE_10]
            s_next.running = 1'b1;
        end
        if (s_reg.running && link.ext_req && ext_data_valid && !s_reg.ext_valid) begin
            s_next.data      = ext_data;
            s_next.ext_valid = 1'b1;
        end
        if (link.terminal_count) begin
            s_next.running = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_reg      <= '0;
            s_reg.cs_b <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign cmd_ready                 = !s_reg.running && !link.terminal_count;
    assign ext_fetch_req             = s_reg.running && link.ext_req && !s_reg.ext_valid;
    assign ext_fetch_index           = link.ext_index;
    assign done_pulse                = s_reg.done;
    assign flag_pulse                = s_reg.flag;
    assign link.chip_select_b        = s_reg.cs_b;
    assign link.write_not_read       = s_reg.wr;
    assign link.register_latch_select = s_reg.sel;
    assign link.strobe               = s_reg.strobe;
    assign link.config_data_bus      = s_reg.data;
    assign link.start                = s_reg.start;
    assign link.channel_select_lines = s_reg.chan;
    assign link.ext_valid            = s_reg.ext_valid;
endmodule
`default_nettype wire

// ===== dv/pag_link_checker.sv
// pag_link_checker: concurrent checks on the scheduler to generator link
// assumes one clock domain and rst_b synchronous active low
`timescale 1ns/100ps
`default_nettype none
module pag_link_checker (
    input wire logic                          clk,
    input wire logic                          rst_b,
    input wire logic                          chip_select_b,
    input wire logic                          write_not_read,
    input wire logic [1:0]                    register_latch_select,
    input wire logic                          strobe,
    input wire logic [pag_pkg::DATA_W-1:0]    config_data_bus,
    input wire logic                          start,
    input wire logic [pag_pkg::CHAN_W-1:0]    channel_select_lines,
    input wire logic                          ext_req,
    input wire logic [pag_pkg::PAT_IDX_W+2:0] ext_index,
    input wire logic                          ext_valid,
    input wire logic                          terminal_count,
    input wire logic                          program_out_flag
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_quiet;
        !terminal_count [*2];
    endsequence
    sequence s_bus_still;
        !strobe [*8];
    endsequence
    a_cs_with_strobe: assert property (strobe |-> !chip_select_b && write_not_read)
        else $error("strobe without chip select or write");
    a_cs_only_strobe: assert property (!chip_select_b |-> strobe)
        else $error("chip select without strobe");
    a_select_legal: assert property (strobe |-> register_latch_select != pag_pkg::SEL_EXT_DATA)
        else $error("unused select code on bus write");
    a_start_pulse: assert property (start |=> !start)
        else $error("start longer than one cycle");
    a_run_ends_tc: assert property (start |=> s_quiet ##[1:1000] terminal_count)
        else $error("run without timely terminal count");
    a_tc_pulse: assert property (terminal_count |=> !terminal_count)
        else $error("terminal count longer than one cycle");
    a_idle_after_tc: assert property (terminal_count |=> !ext_req && !program_out_flag)
        else $error("activity after terminal count");
    a_no_bus_run: assert property (start |=> s_bus_still)
        else $error("bus write during run");
    a_ext_req_hold: assert property (ext_req && !ext_valid |=> ext_req && $stable(ext_index))
        else $error("external request dropped or index moved");
    a_ext_valid_req: assert property (ext_valid |-> ext_req)
        else $error("external byte without request");
endmodule
`default_nettype wire

// ===== dv/test_programmable_address_generator.sv
// test_programmable_address_generator: scheduler and generator joined by pag_if
// assumes 40 MHz clk, inputs driven 2 ns after the rising edge
`timescale 1ns/100ps
`default_nettype none
module test_programmable_address_generator;
    logic                          clk = 1'b0;
    logic                          rst_b = 1'b0;
    logic                          cmd_valid = 1'b0;
    logic [1:0]                    cmd_select = 2'h0;
    logic [7:0]                    cmd_data = 8'h00;
    logic                          cmd_start = 1'b0;
    logic [4:0]                    channel_code = 5'h00;
    logic                          ext_data_valid = 1'b0;
    logic [7:0]                    ext_data = 8'h04;
    logic                          cmd_ready, ext_fetch_req, done_pulse, flag_pulse;
    logic [pag_pkg::PAT_IDX_W+2:0] ext_fetch_index;
    logic [19:0]                   address_out;
    logic                          address_valid, write_enable, read_strobe_clock, busy;
    logic [19:0]                   addr_a [0:511];
    logic                          we_exp = 1'b0;
    int                            n_fail = 0, n_checks = 0, n_addr = 0, n_flag = 0, po_at = -1;
    int                            ext_wait = 3, ext_cnt = 0, ext_n = 0, ext_mod = 1;
    pag_if pag_if_inst ();
    pag_scheduler pag_scheduler_inst (.clk(clk), .rst_b(rst_b), .link(pag_if_inst), .cmd_valid(cmd_valid),
        .cmd_select(cmd_select), .cmd_data(cmd_data), .cmd_start(cmd_start), .channel_code(channel_code),
        .ext_data_valid(ext_data_valid), .ext_data(ext_data), .cmd_ready(cmd_ready),
        .ext_fetch_req(ext_fetch_req), .ext_fetch_index(ext_fetch_index), .done_pulse(done_pulse),
        .flag_pulse(flag_pulse));
    pag_generator pag_generator_inst (.clk(clk), .rst_b(rst_b), .link(pag_if_inst), .address_out(address_out),
        .address_valid(address_valid), .write_enable(write_enable), .read_strobe_clock(read_strobe_clock),
        .busy(busy));
    pag_link_checker pag_link_checker_inst (.clk(clk), .rst_b(rst_b),
        .chip_select_b(pag_if_inst.chip_select_b), .write_not_read(pag_if_inst.write_not_read),
        .register_latch_select(pag_if_inst.register_latch_select), .strobe(pag_if_inst.strobe),
        .config_data_bus(pag_if_inst.config_data_bus), .start(pag_if_inst.start),
        .channel_select_lines(pag_if_inst.channel_select_lines), .ext_req(pag_if_inst.ext_req),
        .ext_index(pag_if_inst.ext_index), .ext_valid(pag_if_inst.ext_valid),
        .terminal_count(pag_if_inst.terminal_count), .program_out_flag(pag_if_inst.program_out_flag));
    always #12.5 clk = ~clk;
    function automatic void check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endfunction
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic req(input logic is_start, input logic [1:0] sel, input logic [7:0] d);
        int k;
        k = 0;
        do begin
            @(posedge clk);
            #2;
            k++;
        end while (cmd_ready !== 1'b1 && k < 3000);
        if (k >= 3000) begin
            check(1'b0, "request not accepted");
            close_out();
        end else begin
            cmd_start = is_start;
            cmd_valid = !is_start;
            cmd_select = sel;
            cmd_data = d;
            @(posedge clk);
            #2;
            cmd_valid = 1'b0;
            cmd_start = 1'b0;
        end
    endtask
    task automatic cfg8(input logic [4:0] idx, input logic [7:0] v);
        req(1'b0, pag_pkg::SEL_ADDR_REG, {3'h0, idx});
        req(1'b0, pag_pkg::SEL_CFG_DATA, v);
    endtask
    task automatic cfg20(input logic [4:0] idx, input logic [19:0] v);
        req(1'b0, pag_pkg::SEL_ADDR_REG, {3'h0, idx});
        req(1'b0, pag_pkg::SEL_CFG_DATA, v[7:0]);
        req(1'b0, pag_pkg::SEL_CFG_DATA, v[15:8]);
        req(1'b0, pag_pkg::SEL_CFG_DATA, {4'h0, v[19:16]});
    endtask
    task automatic run(input logic [4:0] ch, input int n_exp, input string name);
        int k;
        n_addr = 0;
        n_flag = 0;
        po_at = -1;
        ext_n = 0;
        @(posedge clk);
        #2;
        channel_code = ch;
        req(1'b1, 2'h0, 8'h00);
        repeat (3) @(negedge clk);
        check(cmd_ready === 1'b0 && busy === 1'b1, "not busy in run");
        for (k = 0; k < 3000 && done_pulse !== 1'b1; k++) @(negedge clk);
        if (k >= 3000) begin
            check(1'b0, "run did not finish");
            close_out();
        end else begin
            check(n_addr == n_exp, "address count");
            repeat (4) @(negedge clk);
            check(n_addr == n_exp && busy === 1'b0, "not idle after terminal count");
            $display("test %s done", name);
        end
    endtask
    task automatic steps(input int per, input int span, input int lo, input int hi);
        for (int i = 0; i < n_addr; i++) begin
            check(addr_a[i] >= lo && addr_a[i] < hi, "address outside buffer");
            if (i + per < n_addr) check(addr_a[i+per] - addr_a[i] == span, "address step");
        end
    endtask
    always @(negedge clk) begin
        if (rst_b === 1'b1) begin
            check(read_strobe_clock === address_valid, "read strobe");
            check(write_enable === (address_valid & we_exp), "write enable");
            if (address_valid === 1'b1 && n_addr < 512) begin
                if (pag_if_inst.program_out_flag === 1'b1) po_at = n_addr;
                addr_a[n_addr] = address_out;
                n_addr++;
            end
            if (flag_pulse === 1'b1) n_flag++;
        end
    end
    initial forever begin
        @(posedge clk);
        #2;
        if (ext_data_valid === 1'b1) ext_data_valid = 1'b0;
        else if (ext_fetch_req === 1'b1 && ext_cnt >= ext_wait) begin
            check(ext_fetch_index == 8'(ext_n % ext_mod), "external index");
            ext_n++;
            ext_data_valid = 1'b1;
            ext_cnt = 0;
        end else if (ext_fetch_req === 1'b1) ext_cnt++;
    end
    initial begin
        repeat (20) @(posedge clk);
        #2;
        rst_b = 1'b1;
        check(pag_if_inst.chip_select_b === 1'b1 && busy === 1'b0, "reset state");
        run(5'h00, 256, "defaults");
        steps(1, 1, 0, 1 << 20);
        check(po_at == 0 && n_flag == 1, "flag position");
        cfg8(pag_pkg::CFG_PAT_CNT, 8'h03);
        req(1'b0, pag_pkg::SEL_ADDR_REG, 8'h00);
        req(1'b0, pag_pkg::SEL_PAT_DATA, 8'h02);
        req(1'b0, pag_pkg::SEL_PAT_DATA, 8'h03);
        req(1'b0, pag_pkg::SEL_PAT_DATA, 8'h05);
        cfg20(pag_pkg::CFG_LEN0, 20'h00007);
        cfg20(pag_pkg::CFG_PO_POS0, 20'h00004);
        cfg8(pag_pkg::CFG_MODE, 8'h04);
        we_exp = 1'b1;
        run(5'h00, 8, "patterns");
        steps(3, 10, 0, 1 << 20);
        check(po_at == 4 && n_flag == 1, "flag position");
        cfg8(pag_pkg::CFG_PAT_CNT, 8'h01);
        req(1'b0, pag_pkg::SEL_ADDR_REG, 8'h00);
        req(1'b0, pag_pkg::SEL_PAT_DATA, 8'h01);
        cfg20(pag_pkg::CFG_LEN0, 20'h00009);
        cfg20(pag_pkg::CFG_CBUF_SZ0, 20'h00006);
        cfg8(pag_pkg::CFG_MODE, 8'h02);
        we_exp = 1'b0;
        for (int c = 1; c < 32; c += 30) begin
            run(c[4:0], 10, "circular");
            steps(6, 0, c * 6, c * 6 + 6);
        end
        cfg20(pag_pkg::CFG_LEN0, 20'h00004);
        cfg8(pag_pkg::CFG_MODE, 8'h01);
        run(5'h00, 5, "external prompt");
        steps(1, 4, 0, 1 << 20);
        check(ext_n == 5, "fetch count");
        cfg8(pag_pkg::CFG_MODE, 8'h00);
        cfg8(pag_pkg::CFG_PAT_CNT, 8'h21);
        ext_data = 8'h06;
        ext_wait = 9;
        ext_mod = 33;
        run(5'h00, 5, "external slow");
        steps(1, 6, 0, 1 << 20);
        check(ext_n == 5, "fetch count");
        close_out();
    end
endmodule
`default_nettype wire
